// ### verilog/pwm_timer_params.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 second 8-bit interval/PWM timer. Definitions only; included by bare name.
*/
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH
`define CTRL_OFFSET 8'h20
`define CMP_OFFSET 8'h21
`define CTRL_RESET 8'h00
`define CMP_RESET 8'h00
`define BIT_MODE 7
`define BIT_UNUSED 6
`define BIT_CLK_HIGH 5
`define BIT_CLK_LOW 4
`define BIT_COUNT_EN 3
`define BIT_MATCH 2
`define BIT_OUT_SEL 1
`define BIT_IRQ_EN 0
`define DIV_SLOW_A 16
`define DIV_SLOW_B 64
`define CLK_PERIOD_NS 4
`endif

// ### verilog/pwm_timer_pkg.sv
/*
 Types shared by the interval/PWM timer files.
 Assumes the params header supplies all numbers.
*/
package pwm_timer_pkg;
  typedef enum logic [1:0] {
    clk_internal = 2'b00,
    clk_div_a = 2'b01,
    clk_div_b = 2'b10,
    clk_ext_timer = 2'b11
  } clk_sel_t;
  typedef enum logic {
    mode_interval = 1'b0,
    mode_pwm = 1'b1
  } mode_t;
endpackage

// ### verilog/count_tick_gen.sv
/*
 Count-tick generator: turns the clock-select code into a one-cycle tick.
 Assumes instr_tick marks each instruction cycle and ext_tick_level comes
 from the other timer's output, possibly from another domain.
*/
`timescale 1ns/10ps
`include "pwm_timer_params.svh"
module count_tick_gen #(
  parameter int DIV_A = `DIV_SLOW_A,
  parameter int DIV_B = `DIV_SLOW_B
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire pwm_timer_pkg::clk_sel_t clk_sel,
  // Tick sources
  input wire logic instr_tick,
  input wire logic ext_tick_level,
  // Result
  output logic tick
);
  import pwm_timer_pkg::*;

  // The modulo decode needs powers of two that fit the 8-bit prescaler
  initial begin
    if (DIV_A < 2 || DIV_B < 2 || DIV_A > 128 || DIV_B > 128) begin
      $error("count_tick_gen: divider out of range");
    end
    if ((DIV_A & (DIV_A - 1)) != 0 || (DIV_B & (DIV_B - 1)) != 0) begin
      $error("count_tick_gen: dividers must be powers of two");
    end
  end

  logic [7:0] presc;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  wire presc_at_a = (presc % 8'(DIV_A)) == 8'(DIV_A - 1);
  wire presc_at_b = (presc % 8'(DIV_B)) == 8'(DIV_B - 1);
  wire ext_rise = ext_sync & ~ext_prev;
  logic next_tick;

  // Rising edge of the selected count clock
  always_comb begin
    case (clk_sel)
      clk_internal: next_tick = instr_tick;
      clk_div_a: next_tick = instr_tick & presc_at_a;
      clk_div_b: next_tick = instr_tick & presc_at_b;
      clk_ext_timer: next_tick = ext_rise;
      default: next_tick = 1'b0;
    endcase
  end

  // Prescaler held at zero while stopped, so a start is phase aligned
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      presc <= 8'h00;
    end else if (!run) begin
      presc <= 8'h00;
    end else if (instr_tick) begin
      presc <= presc + 8'h01;
    end
  end

  // Two-stage synchroniser, edge taken on the second stage only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      ext_meta <= ext_tick_level;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      tick <= run & next_tick;
    end
  end
endmodule

// ### verilog/pwm_interval_timer_unit2.sv
/*
 Second 8-bit timer: interval timer or PWM generator driving an open-drain
 pin shared with a port bit, plus a level interrupt request.
 Holds the control and compare registers, the 8-bit counter, the waveform
 logic, the pad drive and the level interrupt toward the CPU.
 Assumes a plain register port on ref_clk and a port block that supplies
 its own pin value and direction for the shared pin.
 Assumes instr_tick is a one-cycle pulse on ref_clk, while ext_tick_level
 and the pad read-back may come from anywhere and are synchronised here.
 Assumes software stops the counter, masks and clears the flag before a
 mode change, and keeps the clock select while counting.
*/
// Strobed register access is this design's own decision.
// Contract
// - Output select makes pin a timer output
// - Pin pulls low, releases for high
// - Interval gives square wave, PWM gives PWM
// - Bit 7 selects interval or PWM mode
// - Clock select picks one of four clocks
// - Enable starts; disable stops, clears counter
// - Interval match sets the match flag
// - Interrupt equals flag and enable together
// - No interrupt request in PWM mode
// - Zero write clears flag, one ignored
// - Bit 6 unused, writes ignored
// - Interval match clears counter, counting continues
// - Interval compare loads after next match
// - PWM high until match, low until overflow
// - PWM period 256 ticks, duty compare/256
// - PWM compare loads after next overflow
// - Compare register is write only
// - Interval is compare plus one ticks
// - Dedicated interrupt line, interval matches only
// - After match: toggle, clear, flag, restart
// - Stopped interval mode drives pin low
// - Stopped PWM mode holds pin level
// - Pending flag interrupts as enable rises
`timescale 1ns/10ps
`include "pwm_timer_params.svh"
module pwm_interval_timer_unit2 #(
  parameter int DIV_A = `DIV_SLOW_A,
  parameter int DIV_B = `DIV_SLOW_B
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Count clock sources
  input wire logic instr_tick,
  input wire logic ext_tick_level,
  // Shared port pin, from the port block and the pad read-back
  input wire logic port_data,
  input wire logic port_direction_register,
  input wire logic shared_port_pin_in,
  // Shared port pin, toward the pad (oe low means driving) and the port block
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe_n,
  output logic port_pin_value,
  // Interrupt
  output logic timer_interrupt_line
);
  import pwm_timer_pkg::*;

  // Dividers must be powers of two that fit the 8-bit prescaler
  initial begin
    if (DIV_A < 2 || DIV_A > 128) begin
      $error("pwm_interval_timer_unit2: DIV_A out of range");
    end
    if (DIV_B < 2 || DIV_B > 128) begin
      $error("pwm_interval_timer_unit2: DIV_B out of range");
    end
    if ((DIV_A & (DIV_A - 1)) != 0 || (DIV_B & (DIV_B - 1)) != 0) begin
      $error("pwm_interval_timer_unit2: dividers must be powers of two");
    end
  end

  // Control fields
  logic mode_sel;
  logic clock_select_high;
  logic clock_select_low;
  logic count_enable;
  logic match_flag;
  logic out_sel;
  logic interrupt_enable;

  // Compare staging and active copy
  logic [7:0] pwm_timer_compare;
  logic [7:0] cmp_active;

  // Counter, pending match and waveform level
  logic [7:0] count;
  logic match_pending;
  logic wave;

  // Pad read-back synchroniser stages
  logic pin_meta;
  logic pin_sync;

  // Decode helpers
  function automatic logic field(input logic [7:0] v, input int pos);
    field = v[pos];
  endfunction

  // Address decode, shared by every strobe
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction

  // Mode and clock select as typed views of the control bits
  wire mode_t mode = mode_t'(mode_sel);
  wire clk_sel_t clk_sel = clk_sel_t'({clock_select_high, clock_select_low});
  wire in_interval = (mode == mode_interval);
  wire in_pwm = (mode == mode_pwm);

  // Strobe decode; unmapped addresses fall through and are ignored
  wire wr_ctrl = reg_write & hits(reg_addr, `CTRL_OFFSET);
  wire wr_cmp = reg_write & hits(reg_addr, `CMP_OFFSET);
  wire rd_ctrl = reg_read & hits(reg_addr, `CTRL_OFFSET);

  // Count tick from the tick generator
  wire tick;

  // Write data split into control fields
  wire wd_mode = field(reg_wdata, `BIT_MODE);
  wire wd_clk_high = field(reg_wdata, `BIT_CLK_HIGH);
  wire wd_clk_low = field(reg_wdata, `BIT_CLK_LOW);
  wire wd_count_en = field(reg_wdata, `BIT_COUNT_EN);
  wire wd_match = field(reg_wdata, `BIT_MATCH);
  wire wd_out_sel = field(reg_wdata, `BIT_OUT_SEL);
  wire wd_irq_en = field(reg_wdata, `BIT_IRQ_EN);

  // Tick source: one registered pulse per count-clock rising edge

  count_tick_gen #(
    .DIV_A(DIV_A),
    .DIV_B(DIV_B)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(count_enable),
    .clk_sel(clk_sel),
    .instr_tick(instr_tick),
    .ext_tick_level(ext_tick_level),
    .tick(tick)
  );

  // Counter events; a match is only acted on at the following tick
  wire cmp_hit = (count == cmp_active);
  wire interval_restart = tick & match_pending;
  wire overflow = tick & (count == 8'hff);
  // A stop written in the restart cycle wins, so no flag is raised
  wire stopping = wr_ctrl & ~wd_count_en;
  wire flag_set = interval_restart & in_interval & ~stopping;
  wire flag_clear = wr_ctrl & ~wd_match;

  // Control register; bit 6 has no storage so writes are lost
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_sel <= field(`CTRL_RESET, `BIT_MODE);
      clock_select_high <= field(`CTRL_RESET, `BIT_CLK_HIGH);
      clock_select_low <= field(`CTRL_RESET, `BIT_CLK_LOW);
      count_enable <= field(`CTRL_RESET, `BIT_COUNT_EN);
      out_sel <= field(`CTRL_RESET, `BIT_OUT_SEL);
      interrupt_enable <= field(`CTRL_RESET, `BIT_IRQ_EN);
    end else if (wr_ctrl) begin
      mode_sel <= wd_mode;
      clock_select_high <= wd_clk_high;
      clock_select_low <= wd_clk_low;
      count_enable <= wd_count_en;
      out_sel <= wd_out_sel;
      interrupt_enable <= wd_irq_en;
    end
  end

  // Match flag: a hardware set beats a software clear in the same cycle
  // Writing one to the flag bit leaves it as it is
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      match_flag <= 1'b0;
    end else if (flag_set) begin
      match_flag <= 1'b1;
    end else if (flag_clear) begin
      match_flag <= 1'b0;
    end
  end

  // Compare staging register, write only
  // Reads never see it, so bit operations on it are unsafe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_timer_compare <= `CMP_RESET;
    end else if (wr_cmp) begin
      pwm_timer_compare <= reg_wdata;
    end
  end

  // Active compare reloads while stopped, at a restart or at overflow
  // so a write during counting never cuts a running interval or period
  logic reload;
  assign reload = ~count_enable
    | ((mode == mode_interval) & interval_restart)
    | ((mode == mode_pwm) & overflow);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmp_active <= `CMP_RESET;
    end else if (reload) begin
      cmp_active <= pwm_timer_compare;
    end
  end

  // Counter; interval match is acted on at the next count tick
  // Stopping clears the count at once, whatever the tick
  logic [7:0] next_count;
  wire [7:0] count_plus = count + 8'h01;
  assign next_count = interval_restart ? 8'h00 : count_plus;
  wire [7:0] tick_count = in_pwm ? count_plus : next_count;
  // Pending match: armed at a tick or by a compare hit between ticks
  wire next_pending = in_interval & (next_count == cmp_active) & ~interval_restart;
  wire idle_hit = in_interval & cmp_hit & ~match_pending;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= 8'h00;
      match_pending <= 1'b0;
    end else if (!count_enable) begin
      count <= 8'h00;
      match_pending <= 1'b0;
    end else if (tick) begin
      count <= tick_count;
      match_pending <= next_pending;
    end else if (idle_hit) begin
      match_pending <= 1'b1;
    end
  end

  // PWM level for the count about to be entered; at overflow the new compare applies
  wire [7:0] pwm_cmp_next = overflow ? pwm_timer_compare : cmp_active;
  wire pwm_level_next = pwm_cmp_next > count_plus;
  // Level at count zero before the first tick after a start
  wire pwm_level_zero = cmp_active != 8'h00;

  // Waveform: toggle per interval, PWM high below compare; when stopped, interval goes low and PWM holds
  logic next_wave;
  always_comb begin
    next_wave = wave;
    if (!count_enable) begin
      next_wave = in_pwm ? wave : 1'b0;
    end else if (in_interval) begin
      next_wave = interval_restart ? ~wave : wave;
    end else if (tick) begin
      // Level for the count value about to be entered
      next_wave = pwm_level_next;
    end else if (count == 8'h00) begin
      next_wave = pwm_level_zero;
    end
  end
  // Wave register; stop handling lives in the logic above
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

  // Pad drive: open drain, the port path also only pulls low
  // Port direction is ignored once the timer owns the pin
  wire timer_pull_low = ~next_wave;
  wire port_pull_low = port_direction_register & ~port_data;
  logic next_pin_low;
  assign next_pin_low = out_sel ? timer_pull_low : port_pull_low;
  // Pad output itself is a constant low, only the enable moves
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shared_port_pin_out <= 1'b0;
      shared_port_pin_oe_n <= 1'b1;
    end else begin
      shared_port_pin_out <= 1'b0;
      shared_port_pin_oe_n <= ~next_pin_low;
    end
  end

  // Pin read-back toward the port block, synchronised
  // Third stage gives the port block a clean registered value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      port_pin_value <= 1'b0;
    end else begin
      pin_meta <= shared_port_pin_in;
      pin_sync <= pin_meta;
      port_pin_value <= pin_sync;
    end
  end

  // Interrupt level; registered from the flag and enable as they will stand, so it changes in the same cycle as them
  logic next_irq;
  logic next_irq_en;
  logic next_flag;
  // Only interval matches reach the dedicated request line
  // Flag as it will stand after this edge
  assign next_flag = flag_set | (match_flag & ~flag_clear);
  // Enable as just written, so a pending flag fires at once
  assign next_irq_en = wr_ctrl ? wd_irq_en : interrupt_enable;
  // PWM mode, or a write entering it, masks the request
  assign next_irq = next_flag & next_irq_en & in_interval
                    & ~(wr_ctrl & wd_mode);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_interrupt_line <= 1'b0;
    end else begin
      timer_interrupt_line <= next_irq;
    end
  end

  // Read data: control readable, compare reads zero, bit 6 zero
  logic [7:0] next_rdata;
  // Bit 6 has no storage, so it reads as a fixed zero
  assign next_rdata = rd_ctrl ? {mode_sel,
                                 1'b0,
                                 clock_select_high,
                                 clock_select_low,
                                 count_enable,
                                 match_flag,
                                 out_sel,
                                 interrupt_enable}
                              : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ### verification/pwm_timer_properties.sv
/*
 Checker for the interval/PWM timer: port-level timing of reads, pin and irq.
 Assumes it is bound to the timer top and sees only its ports.
*/
`timescale 1ns/10ps
`include "pwm_timer_params.svh"
module pwm_timer_checker #(
  parameter int DIV_A = `DIV_SLOW_A,
  parameter int DIV_B = `DIV_SLOW_B
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Pin and interrupt
  input wire logic port_data,
  input wire logic port_direction_register,
  input wire logic shared_port_pin_in,
  input wire logic shared_port_pin_out,
  input wire logic shared_port_pin_oe_n,
  input wire logic port_pin_value,
  input wire logic timer_interrupt_line
);
  logic [7:0] ctl;
  logic [1:0] age;
  wire logic pwm_s = ctl[`BIT_MODE];
  wire logic en_s = ctl[`BIT_COUNT_EN];
  wire logic sel_s = ctl[`BIT_OUT_SEL];
  wire logic ie_s = ctl[`BIT_IRQ_EN];
  wire logic idle_iv = sel_s && !en_s && !pwm_s;
  // Shadow of software-owned control bits; flag bit is not trusted here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl <= 8'h00;
      age <= 2'd0;
    end else begin
      if (reg_write && reg_addr == `CTRL_OFFSET) ctl <= reg_wdata;
      if (age != 2'd3) age <= age + 2'd1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property ($past(reg_read && reg_addr != `CTRL_OFFSET) |-> reg_rdata == 8'h00)
    else $error("non-control read not zero");
  a_bit6_zero: assert property ($past(reg_read) |-> !reg_rdata[`BIT_UNUSED])
    else $error("unused bit read set");
  a_pin_out_low: assert property (shared_port_pin_out == 1'b0)
    else $error("pad driven high");
  a_pwm_no_irq: assert property (pwm_s && $past(pwm_s) |-> !timer_interrupt_line)
    else $error("irq in pwm mode");
  a_irq_needs_en: assert property (!ie_s && $past(!ie_s) |-> !timer_interrupt_line)
    else $error("irq while disabled");
  a_irq_follows: assert property ($past(reg_read && reg_addr == `CTRL_OFFSET) && reg_rdata[`BIT_MATCH]
    && reg_rdata[`BIT_IRQ_EN] && !reg_rdata[`BIT_MODE] |-> ##[0:1] timer_interrupt_line)
    else $error("irq missing with flag and enable");
  a_port_path: assert property (!$past(sel_s) |-> shared_port_pin_oe_n == $past(!(port_direction_register && !port_data)))
    else $error("port path wrong");
  a_stop_low: assert property (idle_iv && $past(idle_iv) && $past(idle_iv, 2) |-> !shared_port_pin_oe_n)
    else $error("stopped interval pin not low");
  a_pin_value: assert property (age == 2'd3 |-> port_pin_value == $past(shared_port_pin_in, 3))
    else $error("pin value lag wrong");
  c_irq: cover property ($rose(timer_interrupt_line));
  c_pwm_run: cover property (pwm_s && en_s && shared_port_pin_oe_n);
  c_pin_low: cover property ($fell(shared_port_pin_oe_n));
endmodule
bind pwm_interval_timer_unit2 pwm_timer_checker #(.DIV_A(DIV_A), .DIV_B(DIV_B)) i_pwm_timer_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .port_data(port_data), .port_direction_register(port_direction_register),
  .shared_port_pin_in(shared_port_pin_in), .shared_port_pin_out(shared_port_pin_out),
  .shared_port_pin_oe_n(shared_port_pin_oe_n), .port_pin_value(port_pin_value),
  .timer_interrupt_line(timer_interrupt_line));

// ### verification/open_drain_pad.sv
/*
 Open-drain pad with pull-up, the far side of the timer pin.
 Assumes oe low means the timer pulls the pad.
*/
`timescale 1ns/10ps
module open_drain_pad (
  // From the timer
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Resolved level
  output logic pad
);
  // Pull-up wins when released, so no stale level survives
  assign pad = pin_oe_n ? 1'b1 : pin_out;
endmodule

// ### verification/tb.sv
/*
 Self-checking bench for the interval/PWM timer.
 Assumes the pad model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`include "pwm_timer_params.svh"
module tb;
  logic ref_clk = 0, rst_n = 0, reg_write = 0, reg_read = 0, instr_tick = 0, ext_tick_level = 0;
  logic port_data = 0, port_direction_register = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, d;
  logic [3:0] ec = 0;
  logic [7:0] reg_rdata;
  logic pin_out, oe_n, pad, pin_val, irq;
  int n_errors = 0, comparisons = 0, n, i, c;
  int hp [4] = '{8, 8 * `DIV_SLOW_A, 8 * `DIV_SLOW_B, 80};
  logic [7:0] rows [8][2] = '{'{8'h40, 8'h00}, '{8'h04, 8'h00}, '{8'h33, 8'h33}, '{8'h12, 8'h12},
    '{8'h21, 8'h21}, '{8'h00, 8'h00}, '{8'h80, 8'h80}, '{8'h00, 8'h00}};
  pwm_interval_timer_unit2 i_pwm_interval_timer_unit2 (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .instr_tick(instr_tick), .ext_tick_level(ext_tick_level), .port_data(port_data),
    .port_direction_register(port_direction_register), .shared_port_pin_in(pad), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe_n(oe_n), .port_pin_value(pin_val), .timer_interrupt_line(irq));
  open_drain_pad i_open_drain_pad (.pin_out(pin_out), .pin_oe_n(oe_n), .pad(pad));
  // Clock, instruction tick every other cycle, slow external tick
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    instr_tick <= ~instr_tick;
    ec <= (ec == 4'd9) ? 4'd0 : ec + 4'd1;
    if (ec == 4'd9) ext_tick_level <= ~ext_tick_level;
  end
  task give_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t byte %h want %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task chk_n(input int g, input int e);
    comparisons++;
    if (g != e) begin
      n_errors++;
      $display("mismatch %0t count %0d want %0d", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1;
    @(posedge ref_clk);
    reg_write <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge ref_clk);
    reg_read <= 0;
    #1 v = reg_rdata;
  endtask
  // Cycles until the pad level changes; bounded so a stuck pin cannot hang
  task span(output int k);
    logic v;
    v = pad;
    k = 0;
    while (pad === v && k < 3000) begin
      @(posedge ref_clk);
      #1 k++;
    end
  endtask
  task wait_lvl(input logic v);
    int j;
    j = 0;
    while (pad !== v && j < 3000) begin
      @(posedge ref_clk);
      #1 j++;
    end
    if (pad !== v) chk1(pad, v);
  endtask
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #80000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    rd(`CTRL_OFFSET, d);
    chk(d, `CTRL_RESET);
    wr(`CMP_OFFSET, 8'h5a);
    rd(`CMP_OFFSET, d);
    chk(d, 8'h00);
    rd(8'h22, d);
    chk(d, 8'h00);
    chk1(pad, 1'b1);
    for (i = 0; i < 8; i++) begin
      wr(`CTRL_OFFSET, rows[i][0]);
      rd(`CTRL_OFFSET, d);
      chk(d, rows[i][1]);
    end
    // Interval half period for every clock code, then stop
    for (c = 0; c < 4; c++) begin
      wr(`CMP_OFFSET, 8'h03);
      wr(`CTRL_OFFSET, 8'h0a | 8'(c << 4));
      span(n);
      span(n);
      chk_n(n, hp[c]);
      wait_lvl(1);
      wr(`CTRL_OFFSET, 8'h06 | 8'(c << 4));
      repeat (4) @(posedge ref_clk);
      #1 chk1(pad, 1'b0);
    end
    rd(`CTRL_OFFSET, d);
    chk(d, 8'h36);
    wr(`CTRL_OFFSET, 8'h37);
    rd(`CTRL_OFFSET, d);
    chk1(irq, 1'b1);
    wr(`CTRL_OFFSET, 8'h33);
    rd(`CTRL_OFFSET, d);
    chk(d, 8'h33);
    chk1(irq, 1'b0);
    // PWM duty, period and compare reload at overflow
    wr(`CTRL_OFFSET, 8'h32);
    wr(`CTRL_OFFSET, 8'h82);
    wr(`CMP_OFFSET, 8'h80);
    wr(`CTRL_OFFSET, 8'h8b);
    wait_lvl(0);
    wait_lvl(1);
    fork
      wr(`CMP_OFFSET, 8'h40);
      span(n);
    join
    chk_n(n, 2 * 128);
    span(n);
    chk_n(n, 2 * 128);
    span(n);
    chk_n(n, 2 * 64);
    wait_lvl(1);
    wr(`CTRL_OFFSET, 8'h83);
    repeat (600) @(posedge ref_clk);
    #1 chk1(pad, 1'b1);
    wr(`CTRL_OFFSET, 8'h80);
    wr(`CTRL_OFFSET, 8'h00);
    // Port path when the timer does not own the pin
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {port_direction_register, port_data} <= 2'(i);
      repeat (4) @(posedge ref_clk);
      #1 chk1(pad, i != 2);
      chk1(pin_val, pad);
    end
    wr(`CTRL_OFFSET, 8'h02);
    repeat (4) @(posedge ref_clk);
    #1 chk1(pad, 1'b0);
    give_verdict;
  end
endmodule
